// ===== inc/sector_decoder_consts.svh
`ifndef SECTOR_DECODER_CONSTS_SVH
`define SECTOR_DECODER_CONSTS_SVH

// host bus widths
`define ADDR_W 16
`define PAGE_W 8
`define DATA_W 8

// reference window bounds
`define SRAM_LO 16'h0000
`define SRAM_HI 16'h1fff
`define CTRL_LO 16'h2000
`define CTRL_HI 16'h20ff
`define MAIN0_LO 16'h0000
`define MAIN0_HI 16'h3fff
`define MAIN1_LO 16'h4000
`define MAIN1_HI 16'h7fff
`define PAGED_LOW_LO 16'h8000
`define PAGED_LOW_HI 16'hbfff
`define PAGED_HIGH_LO 16'hc000
`define PAGED_HIGH_HI 16'hffff
`define SEC0_LO 16'h8000
`define SEC0_HI 16'h9fff
`define SEC1_LO 16'ha000
`define SEC1_HI 16'hbfff
`define SEC2_LO 16'hc000
`define SEC2_HI 16'hdfff
`define SEC3_LO 16'he000
`define SEC3_HI 16'hffff

// page values of the paged main sectors
`define PAGE_ANY 8'h00
`define MAIN_PAGE0 8'h00
`define MAIN_PAGE1 8'h01
`define MAIN_PAGE2 8'h02

// routing control register
`define ROUTING_OFFSET 8'he2
`define ROUTE_MAIN_DATA 4
`define ROUTE_SEC_DATA 3
`define ROUTE_MAIN_PROG 2
`define ROUTE_SEC_PROG 1
`define ROUTE_SRAM_PROG 0
`define ROUTE_W 5
`define ROUTE_INIT_DEFAULT 5'h0c
`define RDATA_IDLE 8'h00

`endif

// ===== inc/sector_decoder_pkg.sv
package sector_decoder_pkg;

    // one host bus cycle
    typedef struct packed {
        logic [15:0] address;
        logic [7:0] page;
        logic fetch;
        logic read;
        logic write;
    } bus_cycle_t;

    // one window of the address map
    typedef struct packed {
        logic use_page;
        logic [7:0] page;
        logic [15:0] lo;
        logic [15:0] hi;
    } window_t;

    // final selects
    typedef struct packed {
        logic [7:0] main_flash_sector_select;
        logic [3:0] secondary_flash_segment_select;
        logic sram_select;
        logic control_select;
    } selects_t;

endpackage

// ===== tb/decode_checker.sv
module decode_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // watched inputs
    input wire logic [4:0] route_init,
    input wire sector_decoder_pkg::bus_cycle_t bus_cycle,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    // watched outputs
    input wire logic [7:0] reg_rdata,
    input wire sector_decoder_pkg::selects_t selects,
    input wire logic [4:0] routing
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic rw;
    logic fo;
    assign rw = bus_cycle.read | bus_cycle.write;
    assign fo = bus_cycle.fetch & ~rw;
    sequence s_load;
        $past(reset) && !reset;
    endsequence
    sequence s_wr;
        reg_write && reg_addr == 8'he2 && !$past(reset);
    endsequence
    AST_LOAD: assert property (s_load |=> routing == $past(route_init))
        else $error("routing not loaded");
    AST_WR: assert property (s_wr |=> routing == $past(reg_wdata[4:0]))
        else $error("routing write lost");
    AST_RD: assert property (reg_read |=> reg_rdata ==
        ($past(reg_addr) == 8'he2 ? {3'h0, $past(routing)} : 8'h00))
        else $error("bad read data");
    AST_SRAM: assert property (rw && bus_cycle.address <= 16'h1fff
        |=> selects.sram_select)
        else $error("sram missed");
    AST_CTRL: assert property (rw && bus_cycle.address[15:8] == 8'h20
        |=> selects.control_select)
        else $error("control missed");
    AST_CFETCH: assert property (fo |=> !selects.control_select)
        else $error("control on fetch");
    AST_PAGE: assert property (fo && routing[2] && !routing[1] &&
        bus_cycle.address[15:14] == 2'b10 && bus_cycle.page == 8'h01
        |=> selects.main_flash_sector_select == 8'h10)
        else $error("paged sector wrong");
    AST_MAIN0: assert property (fo && routing[2] && !routing[0] &&
        bus_cycle.address[15:14] == 2'b00 |=> selects.main_flash_sector_select == 8'h01)
        else $error("sector zero wrong");
    AST_SEC: assert property (rw && routing[3] && bus_cycle.address[15] |=>
        selects.secondary_flash_segment_select == 4'h1 << $past(bus_cycle.address[14:13]))
        else $error("segment wrong");
    AST_PRIO: assert property (|selects[5:0] |->
        selects.main_flash_sector_select == 8'h00
        && (selects[1:0] == 2'b00 || selects.secondary_flash_segment_select == 4'h0))
        else $error("two memories selected");
    AST_IDLE: assert property (!(bus_cycle.fetch || rw) |=> selects == '0)
        else $error("select without strobe");
endmodule // decode_checker

bind memory_decode_logic decode_checker u_chk (.ref_clk(ref_clk), .reset(reset),
    .route_init(route_init), .bus_cycle(bus_cycle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .selects(selects), .routing(routing));

// ===== tb/host_core_model.sv
module host_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // request from bench
    input wire logic start,
    input wire sector_decoder_pkg::bus_cycle_t req,
    // host bus
    output sector_decoder_pkg::bus_cycle_t bus_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: strobes low, address and page scrambled
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_cycle <= '0;
        end else if (start) begin
            bus_cycle <= req;
        end else begin
            bus_cycle <= {~bus_cycle.address, ~bus_cycle.page, 3'b000};
        end
    end
endmodule // host_core_model

// ===== tb/tb.sv
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: %h vs %h", $time, (g), (e)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] route;
        logic [2:0] kind;
        logic [15:0] address;
        logic [7:0] page;
        logic [13:0] exp_sel;
    } row_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [4:0] route_init = 5'h1b;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] routing;
    sector_decoder_pkg::bus_cycle_t req = '0;
    sector_decoder_pkg::bus_cycle_t bus_cycle;
    sector_decoder_pkg::selects_t selects;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    // kind is fetch, read, write
    row_t rows [18] = '{
        '{5'h0c, 3'h4, 16'h8000, 8'h01, 14'h0400}, '{5'h0c, 3'h4, 16'hc000, 8'h02, 14'h2000},
        '{5'h0c, 3'h4, 16'h0000, 8'hff, 14'h0040}, '{5'h0c, 3'h4, 16'h8000, 8'h00, 14'h0100},
        '{5'h0c, 3'h4, 16'h8000, 8'h02, 14'h1000}, '{5'h0c, 3'h4, 16'h8000, 8'h03, 14'h0000},
        '{5'h0c, 3'h2, 16'h8000, 8'h00, 14'h0004}, '{5'h0c, 3'h1, 16'he000, 8'h00, 14'h0020},
        '{5'h0c, 3'h2, 16'h1fff, 8'h07, 14'h0002}, '{5'h0c, 3'h1, 16'h20ff, 8'h00, 14'h0001},
        '{5'h0c, 3'h2, 16'h2100, 8'h00, 14'h0000}, '{5'h0c, 3'h4, 16'h2000, 8'h00, 14'h0040},
        '{5'h1f, 3'h4, 16'h1000, 8'h00, 14'h0002}, '{5'h1f, 3'h2, 16'h9fff, 8'h00, 14'h0004},
        '{5'h1f, 3'h1, 16'h4000, 8'h00, 14'h0080}, '{5'h10, 3'h2, 16'hc000, 8'h00, 14'h0200},
        '{5'h02, 3'h4, 16'ha000, 8'h00, 14'h0008}, '{5'h00, 3'h4, 16'h0000, 8'h00, 14'h0000}};

    host_core_model u_host (.ref_clk(ref_clk), .reset(reset), .start(start), .req(req),
        .bus_cycle(bus_cycle));
    memory_decode_logic u_dut (.ref_clk(ref_clk), .reset(reset), .route_init(route_init),
        .bus_cycle(bus_cycle), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .selects(selects), .routing(routing));

    always #2 ref_clk = ~ref_clk;

    task automatic conclude();
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask

    task automatic bus(input row_t r);
        @(posedge ref_clk);
        req <= {r.address, r.page, r.kind};
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk);
        #1 `CHK(selects, r.exp_sel)
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        #1 `CHK(routing, 5'h0c)
        @(posedge ref_clk);
        #1 `CHK(routing, 5'h1b)
        foreach (rows[i]) begin
            wr(8'he2, {3'h0, rows[i].route});
            bus(rows[i]);
        end
        wr(8'he2, 8'hff);
        rd(8'he2, 8'h1f);
        wr(8'he0, 8'h00);
        rd(8'he2, 8'h1f);
        rd(8'he0, 8'h00);
        // main flash to data space only, run from secondary, then restore
        wr(8'he2, 8'h12);
        bus('{5'h12, 3'h4, 16'h8000, 8'h00, 14'h0004});
        bus('{5'h12, 3'h2, 16'hc000, 8'h01, 14'h0800});
        wr(8'he2, 8'h0c);
        bus('{5'h0c, 3'h4, 16'hc000, 8'h01, 14'h0800});
        @(posedge ref_clk);
        route_init <= 5'h07;
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        #1 `CHK(routing, 5'h0c)
        @(posedge ref_clk);
        #1 `CHK(routing, 5'h07)
        // let the reload check in the checker complete
        repeat (2) @(posedge ref_clk);
        conclude();
    end
endmodule // tb

// ===== verilog/memory_decode_logic.sv
// Function
// - eight main flash sector selects, each a 16 KB address window
// - four secondary flash segment selects, each an 8 KB window
// - sram select for data addresses 0000h-1fffh, any page
// - control block select for data addresses 2000h-20ffh
// - paged main sectors 2-7 on pages 0,1,2: low 8000h, high c000h
// - main sectors 0,1 at 0000h-3fffh and 4000h-7fffh, any page
// - secondary segments at 8000h, a000h, c000h, e000h in data space
// - sram and control may overlap core internal ram and registers
// - map fixed by non-volatile configuration, not run-time writes
// - software moves flash between spaces via routing register
// - routing bits: 4 main data, 3 sec data, 2 main/1 sec/0 sram prog
// - initial routing loaded on the first clock after every reset release, 0ch while in reset
// - sram/control beat secondary, secondary beats main flash
`include "sector_decoder_consts.svh"

module memory_decode_logic (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // non-volatile configuration
    input wire logic [`ROUTE_W-1:0] route_init,
    // host bus cycle
    input wire sector_decoder_pkg::bus_cycle_t bus_cycle,
    // routing register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // selects
    output sector_decoder_pkg::selects_t selects,
    output logic [`ROUTE_W-1:0] routing
);
    // fixed map, constant like non-volatile configuration
    localparam sector_decoder_pkg::window_t MAIN_MAP [8] = '{
        '{1'b0, `PAGE_ANY, `MAIN0_LO, `MAIN0_HI},
        '{1'b0, `PAGE_ANY, `MAIN1_LO, `MAIN1_HI},
        '{1'b1, `MAIN_PAGE0, `PAGED_LOW_LO, `PAGED_LOW_HI},
        '{1'b1, `MAIN_PAGE0, `PAGED_HIGH_LO, `PAGED_HIGH_HI},
        '{1'b1, `MAIN_PAGE1, `PAGED_LOW_LO, `PAGED_LOW_HI},
        '{1'b1, `MAIN_PAGE1, `PAGED_HIGH_LO, `PAGED_HIGH_HI},
        '{1'b1, `MAIN_PAGE2, `PAGED_LOW_LO, `PAGED_LOW_HI},
        '{1'b1, `MAIN_PAGE2, `PAGED_HIGH_LO, `PAGED_HIGH_HI}
    };
    localparam sector_decoder_pkg::window_t SEC_MAP [4] = '{
        '{1'b0, `PAGE_ANY, `SEC0_LO, `SEC0_HI},
        '{1'b0, `PAGE_ANY, `SEC1_LO, `SEC1_HI},
        '{1'b0, `PAGE_ANY, `SEC2_LO, `SEC2_HI},
        '{1'b0, `PAGE_ANY, `SEC3_LO, `SEC3_HI}
    };
    localparam sector_decoder_pkg::window_t SRAM_WIN = '{1'b0, `PAGE_ANY, `SRAM_LO, `SRAM_HI};
    localparam sector_decoder_pkg::window_t CTRL_WIN = '{1'b0, `PAGE_ANY, `CTRL_LO, `CTRL_HI};

    logic [7:0] main_hit;
    logic [3:0] sec_hit;
    logic sram_hit;
    logic ctrl_hit;
    logic data_cycle;
    logic main_en;
    logic sec_en;
    logic sram_en;
    logic [7:0] main_sel;
    logic [3:0] sec_sel;
    logic sram_sel;
    logic ctrl_sel;
    logic high_win;
    logic sec_win;
    sector_decoder_pkg::selects_t next_selects;

    routing_control u_routing (
        .ref_clk(ref_clk),
        .reset(reset),
        .route_init(route_init),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .space_routing_control(routing)
    );

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_main
            window_match u_match (
                .address(bus_cycle.address),
                .page(bus_cycle.page),
                .window(MAIN_MAP[i]),
                .hit(main_hit[i])
            );
        end
        for (i = 0; i < 4; i++) begin : g_sec
            window_match u_match (
                .address(bus_cycle.address),
                .page(bus_cycle.page),
                .window(SEC_MAP[i]),
                .hit(sec_hit[i])
            );
        end
    endgenerate

    window_match u_sram (
        .address(bus_cycle.address),
        .page(bus_cycle.page),
        .window(SRAM_WIN),
        .hit(sram_hit)
    );

    window_match u_ctrl (
        .address(bus_cycle.address),
        .page(bus_cycle.page),
        .window(CTRL_WIN),
        .hit(ctrl_hit)
    );

    // strobe qualification through routing enables
    always_comb begin
        data_cycle = bus_cycle.read || bus_cycle.write;
        main_en = (bus_cycle.fetch && routing[`ROUTE_MAIN_PROG])
            || (data_cycle && routing[`ROUTE_MAIN_DATA]);
        sec_en = (bus_cycle.fetch && routing[`ROUTE_SEC_PROG])
            || (data_cycle && routing[`ROUTE_SEC_DATA]);
        sram_en = data_cycle
            || (bus_cycle.fetch && routing[`ROUTE_SRAM_PROG]);
        // control is external data space only, sram also on fetches with routing bit 0; core internal ones never show here
        sram_sel = sram_hit && sram_en;
        ctrl_sel = ctrl_hit && data_cycle;
        sec_sel = sec_en ? sec_hit : 4'h0;
        main_sel = main_en ? main_hit : 8'h00;
    end

    // priority resolution
    always_comb begin
        high_win = sram_sel || ctrl_sel;
        sec_win = |sec_sel;
        next_selects.sram_select = sram_sel;
        next_selects.control_select = ctrl_sel;
        next_selects.secondary_flash_segment_select = high_win ? 4'h0 : sec_sel;
        next_selects.main_flash_sector_select =
            (high_win || sec_win) ? 8'h00 : main_sel;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            selects <= '0;
        end else begin
            selects <= next_selects;
        end
    end
endmodule // memory_decode_logic

// ===== verilog/routing_control.sv
`include "sector_decoder_consts.svh"

module routing_control (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // non-volatile initial value
    input wire logic [`ROUTE_W-1:0] route_init,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // routing out
    output logic [`ROUTE_W-1:0] space_routing_control
);
    logic load_pending;

    // reload initial routing after every reset release
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            load_pending <= 1'b1;
        end else begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            space_routing_control <= `ROUTE_INIT_DEFAULT;
        end else if (load_pending) begin
            space_routing_control <= route_init;
        end else if (reg_write && reg_addr == `ROUTING_OFFSET) begin
            space_routing_control <= reg_wdata[`ROUTE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `RDATA_IDLE;
        end else if (reg_read && reg_addr == `ROUTING_OFFSET) begin
            reg_rdata <= {3'h0, space_routing_control};
        end else begin
            reg_rdata <= `RDATA_IDLE;
        end
    end
endmodule // routing_control

// ===== verilog/window_match.sv
`include "sector_decoder_consts.svh"

module window_match (
    // bus cycle address
    input wire logic [`ADDR_W-1:0] address,
    input wire logic [`PAGE_W-1:0] page,
    // window
    input wire sector_decoder_pkg::window_t window,
    // result
    output logic hit
);
    always_comb begin
        hit = (address >= window.lo) && (address <= window.hi)
            && (!window.use_page || (page == window.page));
    end
endmodule // window_match
